/* rtl/tfc_map.svh */
// Register offsets, field positions, reset values and timing counts of the
// thermometer and frequency compensation block. Definitions only.
`ifndef TFC_MAP_SVH
`define TFC_MAP_SVH

// Register offsets on the serial host port
`define TFC_OFS_TEMP_READING     8'h20
`define TFC_OFS_CTRL             8'h30
`define TFC_OFS_OFFSET_CAL       8'h31
`define TFC_OFS_QUAD_COEF_CAL    8'h32
`define TFC_OFS_TURNOVER_CAL     8'h33

// Control register fields
`define TFC_CTRL_SCAN_SEL_BIT    0
`define TFC_CTRL_THERMO_EN_BIT   1

// Crystal offset register fields
`define TFC_OFFSET_DIR_BIT       7
`define TFC_OFFSET_MAG_MSB       6

// Turnover register field width and the degree shift of its encoding
`define TFC_TURNOVER_MSB         5
`define TFC_TURNOVER_SHIFT_C     64
`define TFC_TEMP_ZERO_CODE       8'h3C

// Reset values (calibration registers come up blank until loaded)
`define TFC_RST_TEMP_READING     8'h00
`define TFC_RST_CTRL             8'h00
`define TFC_RST_OFFSET_CAL       8'h00
`define TFC_RST_QUAD_COEF_CAL    8'h00
`define TFC_RST_TURNOVER_CAL     8'h00

// Timing in reference ticks
`define TFC_REF_HZ               32768
`define TFC_COMP_PERIOD_S        32
`define TFC_SCAN_FAST_S          1
`define TFC_SCAN_SLOW_S          16
`define TFC_COMP_PERIOD_TICKS    (`TFC_COMP_PERIOD_S * `TFC_REF_HZ)
`define TFC_SCAN_FAST_TICKS      (`TFC_SCAN_FAST_S * `TFC_REF_HZ)
`define TFC_SCAN_SLOW_TICKS      (`TFC_SCAN_SLOW_S * `TFC_REF_HZ)
`define TFC_QUAD_SCALE_SHIFT     12

`endif

/* rtl/tfc_pkg.sv */
// Types of the thermometer and frequency compensation block.
// Assumes tfc_map.svh for all numeric constants.
package tfc_pkg;

  // Host register port request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tfc_reg_req_t;

  // Whole block state, registered in one process
  typedef struct packed {
    logic               osc_s1;
    logic               osc_s2;
    logic               osc_prev;
    logic               lv_s1;
    logic               lv_s2;
    logic [7:0]         sens_s1;
    logic [7:0]         sens_s2;
    logic [7:0]         temp_reading;
    logic [7:0]         ctrl;
    logic [7:0]         offset_cal;
    logic [7:0]         quad_coef_cal;
    logic [7:0]         turnover_cal;
    logic [23:0]        scan_cnt;
    logic [23:0]        period_cnt;
    logic [23:0]        spread_acc;
    logic signed [15:0] comp_value;
    logic [1:0]         insert_pend;
    logic               comp_tick;
    logic               corr_add;
    logic               corr_sub;
    logic [7:0]         rdata;
  } tfc_state_t;

endpackage

/* rtl/tfc_thermo_comp.sv */
// Thermometer scheduling and pulse-based frequency compensation.
// Assumes an asynchronous 32.768 kHz oscillator pin, an 8-bit sensor code pin
// and a low-voltage flag pin, all synchronised here to mclk (10 MHz).
//
// Summary of operation
// - Correct time by inserting or suppressing single reference pulses, never retuning.
// - One compensation period spans 32 seconds of reference ticks.
// - Control bit 1 at 30h enables measurement; cleared stops it.
// - Scan select 0 measures every second, 1 every 16 seconds.
// - Scan select sits at bit 0 of the control register.
// - Measurement stored unsigned at 20h; 0 is -60 degrees, 250 is +190.
// - One degree per code step; zero degrees reads 3Ch.
// - Low-voltage flag stops measurement and freezes the last code.
// - Compensation keeps running on the frozen reading during low voltage.
// - Offset bit 7 gives direction: 0 crystal slow, 1 crystal fast.
// - Offset bits 6..0 hold magnitude, valid 0 to 121.
// - Offset cancels turnover error; value is ppm times 1.05.
// - Register 32h holds unsigned quadratic coefficient for parabolic drift.
// - Register 33h bits 5..0 hold turnover, valid 4 to 67.
`timescale 1ns/1ps
`default_nettype none
`include "tfc_map.svh"

module tfc_thermo_comp #(
  parameter int unsigned COMP_PERIOD_TICKS = `TFC_COMP_PERIOD_TICKS,
  parameter int unsigned SCAN_FAST_TICKS   = `TFC_SCAN_FAST_TICKS,
  parameter int unsigned SCAN_SLOW_TICKS   = `TFC_SCAN_SLOW_TICKS
) (
  // Clock, reset, enable
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  // Pins from the analog side
  input  wire logic                 osc_ref_in,
  input  wire logic [7:0]           sensor_code,
  input  wire logic                 low_voltage_flag_1,
  // Host register port
  input  wire tfc_pkg::tfc_reg_req_t reg_req,
  output logic [7:0]                reg_rdata,
  // Compensated reference to the divider chain
  output logic                      comp_tick,
  output logic signed [15:0]        comp_value,
  output logic                      corr_add,
  output logic                      corr_sub
);

  // Counters are 24 bits wide; tick counts above 2^24 - 1 would be cut
  localparam logic [23:0] PERIOD_T = COMP_PERIOD_TICKS[23:0];
  localparam logic [23:0] FAST_T   = SCAN_FAST_TICKS[23:0];
  localparam logic [23:0] SLOW_T   = SCAN_SLOW_TICKS[23:0];

  // Correction clocks per period; positive means add clocks
  // Turnover in code units is 64 plus the field, as codes start at -60 degrees
  // One correction per period is worth about 1 ppm, so the offset adds directly
  function automatic logic signed [15:0] calc_comp(input logic [7:0] temp,
                                                   input logic [7:0] offs,
                                                   input logic [7:0] coef,
                                                   input logic [7:0] turn);
    logic signed [9:0]  dt;
    logic [8:0]         adt;
    logic [17:0]        sq;
    logic [25:0]        prod;
    logic signed [15:0] drift;
    logic signed [15:0] mag;
    dt    = $signed({2'b00, temp}) - 10'sd`TFC_TURNOVER_SHIFT_C
            - $signed({4'h0, turn[`TFC_TURNOVER_MSB:0]});
    adt   = dt[9] ? 9'(-dt) : dt[8:0];
    sq    = 18'(adt * adt);
    prod  = 26'(sq * coef);
    // Scaled square of a far-off reading needs 12 bits; keep all 14 above the cut
    drift = $signed({2'b00, prod[`TFC_QUAD_SCALE_SHIFT +: 14]});
    mag   = $signed({9'h000, offs[`TFC_OFFSET_MAG_MSB:0]});
    // A slow crystal and the always-slow parabola both need added clocks
    calc_comp = offs[`TFC_OFFSET_DIR_BIT] ? drift - mag : drift + mag;
  endfunction

  tfc_pkg::tfc_state_t st;
  tfc_pkg::tfc_state_t next_st;

  always_comb begin
    logic        ref_edge;
    logic        scan_due;
    logic        period_end;
    logic [23:0] scan_limit;
    logic [24:0] acc_sum;
    logic [15:0] abs_comp;
    next_st    = st;
    ref_edge   = 1'b0;
    scan_due   = 1'b0;
    period_end = 1'b0;
    scan_limit = FAST_T;
    acc_sum    = 25'h0000000;
    abs_comp   = 16'h0000;

    // Each pin passes two flops; logic reads the second stage, plus osc_prev for the oscillator edge
    // Limitation: the sensor word has no handshake, so the analog side must
    // hold it steady for a few clocks around each scan
    next_st.osc_s1   = osc_ref_in;
    next_st.osc_s2   = st.osc_s1;
    next_st.osc_prev = st.osc_s2;
    next_st.lv_s1    = low_voltage_flag_1;
    next_st.lv_s2    = st.lv_s1;
    next_st.sens_s1  = sensor_code;
    next_st.sens_s2  = st.sens_s1;
    // Rising edge of the synchronised oscillator is one reference tick
    ref_edge         = st.osc_s2 & ~st.osc_prev;
    next_st.comp_tick = 1'b0;
    next_st.corr_add  = 1'b0;
    next_st.corr_sub  = 1'b0;

    // Host writes; a scan in the same cycle overrides the temperature
    if (reg_req.wr) begin
      case (reg_req.addr)
        `TFC_OFS_TEMP_READING:  next_st.temp_reading  = reg_req.wdata;
        `TFC_OFS_CTRL:          next_st.ctrl          = reg_req.wdata;
        `TFC_OFS_OFFSET_CAL:    next_st.offset_cal    = reg_req.wdata;
        `TFC_OFS_QUAD_COEF_CAL: next_st.quad_coef_cal = reg_req.wdata;
        `TFC_OFS_TURNOVER_CAL:  next_st.turnover_cal  = reg_req.wdata;
        default: begin
        end
      endcase
    end

    // Read data follows the address every cycle; there is no read strobe
    case (reg_req.addr)
      `TFC_OFS_TEMP_READING:  next_st.rdata = st.temp_reading;
      `TFC_OFS_CTRL:          next_st.rdata = st.ctrl;
      `TFC_OFS_OFFSET_CAL:    next_st.rdata = st.offset_cal;
      `TFC_OFS_QUAD_COEF_CAL: next_st.rdata = st.quad_coef_cal;
      `TFC_OFS_TURNOVER_CAL:  next_st.rdata = st.turnover_cal;
      default:                next_st.rdata = 8'h00;
    endcase

    if (st.ctrl[`TFC_CTRL_SCAN_SEL_BIT]) begin
      scan_limit = SLOW_T;
    end

    if (ref_edge) begin
      // Scan timer free-runs so the interval stays regular when re-enabled
      if (st.scan_cnt >= scan_limit - 24'h000001) begin
        next_st.scan_cnt = 24'h000000;
        scan_due         = 1'b1;
      end else begin
        next_st.scan_cnt = st.scan_cnt + 24'h000001;
      end
      if (st.period_cnt == PERIOD_T - 24'h000001) begin
        next_st.period_cnt = 24'h000000;
        period_end         = 1'b1;
      end else begin
        next_st.period_cnt = st.period_cnt + 24'h000001;
      end

      // Spread the period's corrections evenly over its ticks
      // rather than bunching them, so each second carries its share
      abs_comp = st.comp_value[15] ? 16'(-st.comp_value) : 16'(st.comp_value);
      acc_sum  = {1'b0, st.spread_acc} + {9'h000, abs_comp};
      next_st.comp_tick = 1'b1;
      if (acc_sum >= {1'b0, PERIOD_T}) begin
        next_st.spread_acc = 24'(acc_sum - {1'b0, PERIOD_T});
        if (st.comp_value[15]) begin
          next_st.comp_tick = 1'b0;
          next_st.corr_sub  = 1'b1;
        end else if (st.comp_value != 16'sh0000) begin
          next_st.insert_pend = 2'h2;
          next_st.corr_add    = 1'b1;
        end
      end else begin
        next_st.spread_acc = acc_sum[23:0];
      end
    end

    // Extra tick with one idle cycle so the divider sees a separate pulse
    // A pending insertion lasts two cycles, well inside one reference tick
    if (st.insert_pend == 2'h2) begin
      next_st.insert_pend = 2'h1;
    end else if (st.insert_pend == 2'h1) begin
      next_st.insert_pend = 2'h0;
      next_st.comp_tick   = 1'b1;
    end

    // Measurement suspended under low voltage; reading stays frozen
    if (scan_due && st.ctrl[`TFC_CTRL_THERMO_EN_BIT] && !st.lv_s2) begin
      next_st.temp_reading = st.sens_s2;
    end

    // New value each period from whatever the register holds, frozen or not
    if (period_end) begin
      next_st.comp_value = calc_comp(st.temp_reading, st.offset_cal,
                                     st.quad_coef_cal, st.turnover_cal);
      next_st.spread_acc = 24'h000000;
    end
  end

  // A low enable freezes everything, synchronisers included, so a stalled
  // clock never shows a false reference edge when it resumes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st               <= '0;
      st.temp_reading  <= `TFC_RST_TEMP_READING;
      st.ctrl          <= `TFC_RST_CTRL;
      st.offset_cal    <= `TFC_RST_OFFSET_CAL;
      st.quad_coef_cal <= `TFC_RST_QUAD_COEF_CAL;
      st.turnover_cal  <= `TFC_RST_TURNOVER_CAL;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign reg_rdata  = st.rdata;
  assign comp_tick  = st.comp_tick;
  assign comp_value = st.comp_value;
  assign corr_add   = st.corr_add;
  assign corr_sub   = st.corr_sub;

endmodule

`default_nettype wire

/* tb/tfc_asserts.sv */
// Concurrent checks of the thermometer and compensation block.
// Assumes the top module's ports only; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module tfc_asserts (
  // Clock and control
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  ce,
  input wire logic                  low_voltage_flag_1,
  // Register port
  input wire tfc_pkg::tfc_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  // Compensated reference
  input wire logic                  comp_tick,
  input wire logic                  corr_add,
  input wire logic                  corr_sub
);
  default clocking @(posedge mclk); endclocking
  // A stalled clock enable freezes all state, so checks pause with it
  default disable iff (sys_rst || !ce);
  logic cal;
  assign cal = reg_req.addr[7:2] == 6'h0C;
  add_sub_excl_a: assert property (!(corr_add && corr_sub))
    else $error("insert and suppress together");
  sub_no_tick_a: assert property (corr_sub |-> !comp_tick)
    else $error("suppressed tick still passed");
  add_extra_a: assert property (corr_add |-> comp_tick ##1 !comp_tick ##1 comp_tick)
    else $error("inserted tick missing");
  tick_pulse_a: assert property (comp_tick |=> !comp_tick)
    else $error("tick longer than one cycle");
  corr_pulse_a: assert property (corr_add || corr_sub |=> !corr_add && !corr_sub)
    else $error("correction pulse too long");
  unmapped_rd_a: assert property (!cal && reg_req.addr != 8'h20 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cal_rdbk_a: assert property (reg_req.wr && cal ##1 !reg_req.wr && $stable(reg_req.addr)
    |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("written value not read back");
  temp_freeze_a: assert property (low_voltage_flag_1 [*4] ##1
    (low_voltage_flag_1 && !reg_req.wr && reg_req.addr == 8'h20) [*2] |=> $stable(reg_rdata))
    else $error("temperature moved at low voltage");
  add_c: cover property (corr_add);
  sub_c: cover property (corr_sub);
  frz_c: cover property (low_voltage_flag_1 && reg_req.addr == 8'h20);
endmodule
bind tfc_thermo_comp tfc_asserts i_chk (.mclk, .sys_rst, .ce, .low_voltage_flag_1,
  .reg_req, .reg_rdata, .comp_tick, .corr_add, .corr_sub);
`default_nettype wire

/* tb/thermometer_freq_compensation_test.sv */
// Self-checking bench of the thermometer and compensation block.
// Assumes shortened scan and period counts; the oscillator ticks every 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module thermometer_freq_compensation_test;
  logic mclk = 0, sys_rst = 1, ce = 1, osc = 0, lv = 0;
  logic [7:0] sens = 8'h00;
  tfc_pkg::tfc_reg_req_t req = '0;
  logic [7:0] rdata;
  logic tick, cadd, csub;
  logic signed [15:0] cval;
  int fails = 0, check_count = 0, nadd = 0, nsub = 0;
  always #50 mclk = ~mclk;
  always #400 osc = ~osc;
  always @(posedge mclk) begin
    nadd += cadd;
    nsub += csub;
  end
  tfc_thermo_comp #(.COMP_PERIOD_TICKS(64), .SCAN_FAST_TICKS(4), .SCAN_SLOW_TICKS(16)) i_dut (
    .mclk, .sys_rst, .ce, .osc_ref_in(osc), .sensor_code(sens), .low_voltage_flag_1(lv),
    .reg_req(req), .reg_rdata(rdata), .comp_tick(tick), .comp_value(cval),
    .corr_add(cadd), .corr_sub(csub));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    #1 req = '{1'b1, a, d};
    @(posedge mclk);
    #1 req.wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk);
    #1 req = '{1'b0, a, 8'h00};
    @(posedge mclk);
    #1 chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
  endtask
  // Bounded poll: a scan lands at most one slow interval away
  task automatic wait_temp(logic [7:0] exp);
    int i;
    @(posedge mclk);
    #1 req.addr = 8'h20;
    for (i = 0; i < 300 && rdata !== exp; i++) @(posedge mclk) #1;
    chk("temp poll", {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic comp_stage(logic [7:0] offs, logic [7:0] coef, logic [15:0] exp, int na, int ns);
    wr(8'h31, offs);
    wr(8'h32, coef);
    rd(8'h20, 8'h5C);
    repeat (1100) @(posedge mclk);
    #1 chk("comp value", exp, cval);
    nadd = 0;
    nsub = 0;
    repeat (520) @(posedge mclk);
    #1 chk("corrections", 16'h1,
           {15'h0, nadd >= na && nsub >= ns && (nadd == 0 || nsub == 0)});
  endtask
  // Two offset changes: their results land one period (64 ticks of 8 clocks) apart
  task automatic period_len;
    int n;
    wr(8'h31, 8'h86);
    for (n = 0; n < 600 && cval !== 16'hFFFA; n++) @(posedge mclk) #1;
    wr(8'h31, 8'h87);
    for (n = 0; n < 600 && cval !== 16'hFFF9; n++) @(posedge mclk) #1;
    chk("period clocks", 16'd512, 16'(n + 2));
  endtask
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 sys_rst = 0;
    rd(8'h20, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h33, 8'hC8);
    rd(8'h33, 8'hC8);
    wr(8'h34, 8'h5A);
    rd(8'h34, 8'h00);
    ce = 0;
    wr(8'h32, 8'h11);
    ce = 1;
    rd(8'h32, 8'h00);
    wr(8'h20, 8'h3C);
    rd(8'h20, 8'h3C);
    sens = 8'h55;
    wr(8'h30, 8'h02);
    wait_temp(8'h55);
    wr(8'h20, 8'h11);
    repeat (60) @(posedge mclk);
    rd(8'h20, 8'h55);
    sens = 8'h66;
    wr(8'h30, 8'h03);
    wait_temp(8'h66);
    sens = 8'h77;
    repeat (90) @(posedge mclk);
    rd(8'h20, 8'h66);
    wait_temp(8'h77);
    wr(8'h30, 8'h00);
    wr(8'h20, 8'h5C);
    lv = 1;
    wr(8'h30, 8'h02);
    sens = 8'h10;
    comp_stage(8'h05, 8'hFF, 16'd29, 28, 0);
    comp_stage(8'h85, 8'h00, 16'hFFFB, 0, 4);
    period_len;
    lv = 0;
    wait_temp(8'h10);
    stop_test;
  end
endmodule
`default_nettype wire
